// File: cpu_flags_and_core_registers.sv
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cpu_flags_and_core_registers
	import core_regs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic watchdog_timeout,
	input wire logic [15:0] program_word,
	output logic [core_regs_pkg::PC_W-1:0] program_counter,
	output logic [core_regs_pkg::PC_W-1:0] table_address,
	output logic table_fetch,
	output logic dummy_cycle,
	output logic irq
);
	import core_regs_pkg::*;

	logic [7:0] working_q, working_d;
	logic [7:0] operand_q, operand_d;
	logic [5:0] flag_q, flag_d;
	logic [PC_W-1:0] pc_q, pc_d;
	logic [7:0] table_pointer_q, table_pointer_d;
	logic [7:0] table_high_q, table_high_d;
	logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
	logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;
	logic [31:0] rdata_q, rdata_d;
	logic ack_q, ack_d;
	logic dummy_q, dummy_d;
	logic fetch_q, fetch_d;
	logic irq_q, irq_d;
	logic [PC_W-1:0] taddr_q, taddr_d;
	logic cmd_dest_q, cmd_dest_d;
	seq_state_e state_q, state_d;
	logic [7:0] alu_result;
	logic [3:0] alu_flags, alu_update;
	logic [3:0] cmd_op;
	logic req, wr, wr_lane0;
	logic [IRQ_W-1:0] irq_events;

	assign req = wb_cyc_i && wb_stb_i && !ack_q && !dummy_q && state_q == ST_IDLE;
	assign wr = req && wb_we_i;
	assign wr_lane0 = wr && wb_sel_i[0];
	assign cmd_op = wb_dat_i[3:0];

	alu_core u_alu (
		.op(cmd_op),
		.acc(working_q),
		.mem(operand_q),
		.carry_in(flag_q[FLAG_CARRY]),
		.result(alu_result),
		.flags(alu_flags),
		.update(alu_update)
	);

	// datapath, flags, program counter and bus sequencing
	always_comb begin
		working_d = working_q;
		operand_d = operand_q;
		flag_d = flag_q;
		pc_d = pc_q;
		table_pointer_d = table_pointer_q;
		table_high_d = table_high_q;
		irq_mask_d = irq_mask_q;
		rdata_d = rdata_q;
		ack_d = 1'b0;
		dummy_d = 1'b0;
		fetch_d = 1'b0;
		taddr_d = taddr_q;
		cmd_dest_d = cmd_dest_q;
		state_d = state_q;
		irq_events = '0;
		unique case (state_q)
			ST_IDLE: begin
				if (req) begin
					ack_d = 1'b1;
					rdata_d = 32'h0000_0000;
					unique case (wb_adr_i)
						OFS_WORKING: rdata_d[7:0] = working_q;
						OFS_FLAGS: rdata_d[5:0] = flag_q;
						OFS_PC_LOW: rdata_d[7:0] = pc_q[7:0];
						OFS_PC_FULL: rdata_d[PC_W-1:0] = pc_q;
						OFS_TABLE_PTR: rdata_d[7:0] = table_pointer_q;
						OFS_TABLE_HIGH: rdata_d[7:0] = table_high_q;
						OFS_OPERAND: rdata_d[7:0] = operand_q;
						OFS_IRQ_STATUS: rdata_d[IRQ_W-1:0] = irq_stat_q;
						OFS_IRQ_MASK: rdata_d[IRQ_W-1:0] = irq_mask_q;
						default: rdata_d = 32'h0000_0000;
					endcase
				end
				if (wr_lane0) begin
					unique case (wb_adr_i)
						OFS_WORKING: working_d = wb_dat_i[7:0];
						// arithmetic flags only; bits 5 and 4 untouched
						OFS_FLAGS: flag_d[3:0] = wb_dat_i[3:0];
						OFS_PC_LOW: begin
							pc_d = {pc_q[PC_W-1:8], wb_dat_i[7:0]};
							dummy_d = 1'b1;
							irq_events[IRQ_JUMP] = 1'b1;
						end
						OFS_TABLE_PTR: table_pointer_d = wb_dat_i[7:0];
						OFS_OPERAND: operand_d = wb_dat_i[7:0];
						OFS_IRQ_MASK: irq_mask_d = wb_dat_i[IRQ_W-1:0];
						OFS_COMMAND: begin
							pc_d = pc_q + 12'h001;
							unique case (cmd_op)
								OP_STORE: operand_d = working_q;
								OP_SLEEP: begin
									flag_d[FLAG_SLEEP] = 1'b1;
									flag_d[FLAG_WDOG] = 1'b0;
								end
								OP_WDOG_CLEAR: begin
									flag_d[FLAG_SLEEP] = 1'b0;
									flag_d[FLAG_WDOG] = 1'b0;
								end
								OP_TABLE: begin
									ack_d = 1'b0;
									fetch_d = 1'b1;
									taddr_d = {pc_q[PC_W-1:8], table_pointer_q};
									cmd_dest_d = wb_dat_i[CMD_DEST_BIT];
									state_d = ST_FETCH;
								end
								OP_NOP, OP_SPARE: pc_d = pc_q + 12'h001;
								default: begin
									// operand destination only when named
									if (wb_dat_i[CMD_DEST_BIT])
										operand_d = alu_result;
									else
										working_d = alu_result;
									for (int i = 0; i < 4; i++) begin
										if (alu_update[i])
											flag_d[i] = alu_flags[i];
									end
								end
							endcase
						end
						default: working_d = working_q;
					endcase
				end
			end
			ST_FETCH: begin
				// program word is taken in the cycle the fetch strobe is high
				table_high_d = program_word[15:8];
				if (cmd_dest_q)
					operand_d = program_word[7:0];
				else
					working_d = program_word[7:0];
				irq_events[IRQ_TABLE] = 1'b1;
				ack_d = 1'b1;
				state_d = ST_IDLE;
			end
		endcase
		// timeout set wins over any clear in the same cycle
		if (watchdog_timeout) begin
			flag_d[FLAG_WDOG] = 1'b1;
			irq_events[IRQ_WDOG] = 1'b1;
		end
	end

	// sticky interrupt status, write one to clear, set wins
	always_comb begin
		irq_stat_d = irq_stat_q;
		if (wr_lane0 && wb_adr_i == OFS_IRQ_STATUS)
			irq_stat_d = irq_stat_q & ~wb_dat_i[IRQ_W-1:0];
		irq_stat_d = irq_stat_d | irq_events;
		irq_d = |(irq_stat_d & irq_mask_d);
	end

	// state registers; no flag copy exists for calls or interrupts
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			working_q <= BYTE_RESET;
			operand_q <= BYTE_RESET;
			flag_q <= FLAGS_RESET;
			pc_q <= PC_RESET;
			table_pointer_q <= BYTE_RESET;
			table_high_q <= BYTE_RESET;
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			rdata_q <= 32'h0000_0000;
			ack_q <= 1'b0;
			dummy_q <= 1'b0;
			fetch_q <= 1'b0;
			irq_q <= 1'b0;
			taddr_q <= PC_RESET;
			cmd_dest_q <= 1'b0;
			state_q <= ST_IDLE;
		end else if (clk_en) begin
			working_q <= working_d;
			operand_q <= operand_d;
			flag_q <= flag_d;
			pc_q <= pc_d;
			table_pointer_q <= table_pointer_d;
			table_high_q <= table_high_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			rdata_q <= rdata_d;
			ack_q <= ack_d;
			dummy_q <= dummy_d;
			fetch_q <= fetch_d;
			irq_q <= irq_d;
			taddr_q <= taddr_d;
			cmd_dest_q <= cmd_dest_d;
			state_q <= state_d;
		end
	end

	assign wb_dat_o = rdata_q;
	assign wb_ack_o = ack_q;
	assign program_counter = pc_q;
	assign table_address = taddr_q;
	assign table_fetch = fetch_q;
	assign dummy_cycle = dummy_q;
	assign irq = irq_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	flag_write_guard_a: assert property (
		(clk_en && wr_lane0 && wb_adr_i == OFS_FLAGS && !watchdog_timeout)
		|=> flag_q[5:4] == $past(flag_q[5:4]) && flag_q[3:0] == $past(wb_dat_i[3:0]))
		else $error("flag write altered protected bits");
	add_carry_a: assert property (
		(clk_en && wr_lane0 && wb_adr_i == OFS_COMMAND && cmd_op == OP_ADD)
		|=> flag_q[FLAG_CARRY] == ($past({1'b0, working_q} + {1'b0, operand_q}) > 9'h0FF))
		else $error("carry wrong after add");
	zero_flag_a: assert property (
		(clk_en && wr_lane0 && wb_adr_i == OFS_COMMAND && cmd_op == OP_XOR
		&& !wb_dat_i[CMD_DEST_BIT])
		|=> flag_q[FLAG_ZERO] == (working_q == 8'h00))
		else $error("zero flag does not match result");
	sleep_flag_a: assert property (
		(clk_en && $changed(flag_q[FLAG_SLEEP]))
		|-> $past(wr_lane0 && wb_adr_i == OFS_COMMAND
		&& (cmd_op == OP_SLEEP || cmd_op == OP_WDOG_CLEAR)))
		else $error("sleep flag changed without cause");
	wdog_flag_a: assert property (
		$rose(flag_q[FLAG_WDOG]) |-> $past(watchdog_timeout))
		else $error("watchdog flag set without timeout");
	pc_jump_a: assert property (
		(clk_en && wr_lane0 && wb_adr_i == OFS_PC_LOW)
		|=> pc_q == {$past(pc_q[PC_W-1:8]), $past(wb_dat_i[7:0])} && dummy_q)
		else $error("low byte jump left page or skipped");
	dummy_stall_a: assert property (
		(clk_en && dummy_q) |=> !ack_q)
		else $error("request served during dummy cycle");
	table_read_a: assert property (
		(clk_en && fetch_q) |=> table_high_q == $past(program_word[15:8]) && ack_q)
		else $error("table high byte not captured");
	upper_zero_a: assert property (
		(ack_q && $past(wb_adr_i) == OFS_FLAGS) |-> wb_dat_o[7:6] == 2'b00)
		else $error("unimplemented flag bits read nonzero");
endmodule : cpu_flags_and_core_registers
`default_nettype wire

// File: core_regs_pkg.sv
package core_regs_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFS_WORKING = 8'h00;
	localparam logic [7:0] OFS_FLAGS = 8'h04;
	localparam logic [7:0] OFS_PC_LOW = 8'h08;
	localparam logic [7:0] OFS_PC_FULL = 8'h0C;
	localparam logic [7:0] OFS_TABLE_PTR = 8'h10;
	localparam logic [7:0] OFS_TABLE_HIGH = 8'h14;
	localparam logic [7:0] OFS_OPERAND = 8'h18;
	localparam logic [7:0] OFS_COMMAND = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
	// flag register bit positions
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_NIBBLE = 1;
	localparam int FLAG_ZERO = 2;
	localparam int FLAG_WRAP = 3;
	localparam int FLAG_SLEEP = 4;
	localparam int FLAG_WDOG = 5;
	localparam logic [5:0] FLAGS_RESET = 6'h00;
	// command register fields
	localparam int CMD_DEST_BIT = 4;
	// interrupt status bits
	localparam int IRQ_WDOG = 0;
	localparam int IRQ_JUMP = 1;
	localparam int IRQ_TABLE = 2;
	localparam int IRQ_W = 3;
	localparam int PC_W = 12;
	localparam logic [PC_W-1:0] PC_RESET = 12'h000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	typedef enum logic [3:0] {
		OP_ADD = 4'h0,
		OP_SUB = 4'h1,
		OP_AND = 4'h2,
		OP_OR = 4'h3,
		OP_XOR = 4'h4,
		OP_RLC = 4'h5,
		OP_RRC = 4'h6,
		OP_INC = 4'h7,
		OP_DEC = 4'h8,
		OP_LOAD = 4'h9,
		OP_STORE = 4'hA,
		OP_TABLE = 4'hB,
		OP_SLEEP = 4'hC,
		OP_WDOG_CLEAR = 4'hD,
		OP_NOP = 4'hE,
		OP_SPARE = 4'hF
	} alu_op_e;
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_FETCH = 1'b1
	} seq_state_e;
endpackage : core_regs_pkg

// File: alu_core.sv
`timescale 1ns/1ps
`default_nettype none
module alu_core
	import core_regs_pkg::*;
(
	input wire logic [3:0] op,
	input wire logic [7:0] acc,
	input wire logic [7:0] mem,
	input wire logic carry_in,
	output logic [7:0] result,
	output logic [3:0] flags,
	output logic [3:0] update
);
	logic [7:0] addend;
	logic cin;
	logic [8:0] sum;
	logic [4:0] low_sum;
	logic [7:0] low7_sum;

	// shared adder; subtract adds the inverted operand plus one
	always_comb begin
		addend = mem;
		cin = 1'b0;
		if (op == OP_SUB) begin
			addend = ~mem;
			cin = 1'b1;
		end else if (op == OP_INC) begin
			addend = 8'h01;
		end else if (op == OP_DEC) begin
			addend = 8'hFF;
		end
		sum = {1'b0, (op == OP_INC || op == OP_DEC) ? mem : acc} + {1'b0, addend} + {8'h00, cin};
		low_sum = {1'b0, acc[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
		low7_sum = {1'b0, acc[6:0]} + {1'b0, addend[6:0]} + {7'h00, cin};
	end

	// result and flag candidates per operation
	always_comb begin
		result = acc;
		flags = 4'h0;
		update = 4'h0;
		unique case (op)
			OP_ADD, OP_SUB: begin
				result = sum[7:0];
				flags[FLAG_CARRY] = sum[8];
				flags[FLAG_NIBBLE] = low_sum[4];
				flags[FLAG_WRAP] = low7_sum[7] ^ sum[8];
				update = 4'hF;
			end
			OP_AND: begin
				result = acc & mem;
				update[FLAG_ZERO] = 1'b1;
			end
			OP_OR: begin
				result = acc | mem;
				update[FLAG_ZERO] = 1'b1;
			end
			OP_XOR: begin
				result = acc ^ mem;
				update[FLAG_ZERO] = 1'b1;
			end
			OP_RLC: begin
				result = {mem[6:0], carry_in};
				flags[FLAG_CARRY] = mem[7];
				update[FLAG_CARRY] = 1'b1;
			end
			OP_RRC: begin
				result = {carry_in, mem[7:1]};
				flags[FLAG_CARRY] = mem[0];
				update[FLAG_CARRY] = 1'b1;
			end
			OP_INC, OP_DEC: begin
				result = sum[7:0];
				update[FLAG_ZERO] = 1'b1;
			end
			OP_LOAD: result = mem;
			default: result = acc;
		endcase
		flags[FLAG_ZERO] = (result == 8'h00);
	end
endmodule : alu_core
`default_nettype wire

// File: cpu_flags_and_core_registers_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module cpu_flags_and_core_registers_bench;
	import core_regs_pkg::*;
	logic ref_clk, reset_n, clk_en, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, watchdog_timeout;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [15:0] program_word;
	logic [PC_W-1:0] program_counter, table_address, seen_tab;
	logic table_fetch, dummy_cycle, irq;
	logic [7:0] rd;
	logic [3:0] bus_sel = 4'hF;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	int dummy_count = 0;
	cpu_flags_and_core_registers i_cpu_flags_and_core_registers (.ref_clk(ref_clk),
		.reset_n(reset_n), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .watchdog_timeout(watchdog_timeout),
		.program_word(program_word), .program_counter(program_counter),
		.table_address(table_address), .table_fetch(table_fetch),
		.dummy_cycle(dummy_cycle), .irq(irq));
	// clock generator
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// program memory stand-in, word valid only while the fetch strobe is high
	assign program_word = table_fetch ? 16'hBEEF : 16'h0000;
	// watch fetch address and dummy cycles where they are settled
	always @(negedge ref_clk) begin
		if (table_fetch === 1'b1) seen_tab = table_address;
		if (dummy_cycle === 1'b1) dummy_count++;
	end
	// hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim
	// one classic wishbone cycle; ack and read data taken at one rising edge
	task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= bus_sel;
		wb_dat_i <= {24'h000000, dat};
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			num_errors++;
			end_sim();
		end
		rd = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : bus
	task automatic chk_reg(input logic [7:0] adr, input logic [7:0] exp, input string nm);
		bus(1'b0, adr, 8'h00);
		`CHK(nm, exp, rd)
	endtask : chk_reg
	task automatic cmd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] c);
		bus(1'b1, OFS_WORKING, a);
		bus(1'b1, OFS_OPERAND, m);
		bus(1'b1, OFS_COMMAND, c);
	endtask : cmd
	// main sequence
	initial begin
		reset_n = 1'b0;
		clk_en = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h00000000;
		watchdog_timeout = 1'b0;
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		chk_reg(OFS_FLAGS, 8'h00, "flags reset");
		cmd(8'h7F, 8'h01, 8'h00);
		chk_reg(OFS_FLAGS, 8'h0A, "add flags");
		chk_reg(OFS_WORKING, 8'h80, "add result");
		cmd(8'h10, 8'h01, 8'h11);
		chk_reg(OFS_FLAGS, 8'h01, "sub flags");
		chk_reg(OFS_OPERAND, 8'h0F, "sub to operand");
		chk_reg(OFS_WORKING, 8'h10, "working kept");
		cmd(8'h0F, 8'hF0, 8'h02);
		chk_reg(OFS_FLAGS, 8'h05, "zero flag");
		cmd(8'h00, 8'h40, 8'h05);
		chk_reg(OFS_WORKING, 8'h81, "rotate left");
		chk_reg(OFS_FLAGS, 8'h04, "rotate left flags");
		cmd(8'h00, 8'h01, 8'h06);
		chk_reg(OFS_WORKING, 8'h00, "rotate right");
		chk_reg(OFS_FLAGS, 8'h05, "rotate right flags");
		bus(1'b1, OFS_FLAGS, 8'hFF);
		chk_reg(OFS_FLAGS, 8'h0F, "flag write");
		bus(1'b1, OFS_IRQ_MASK, 8'h01);
		@(posedge ref_clk);
		watchdog_timeout <= 1'b1;
		@(posedge ref_clk);
		watchdog_timeout <= 1'b0;
		chk_reg(OFS_FLAGS, 8'h2F, "timeout flag");
		chk_reg(OFS_IRQ_STATUS, 8'h01, "irq status");
		`CHK("irq raised", 1'b1, irq)
		bus(1'b1, OFS_IRQ_STATUS, 8'h07);
		chk_reg(OFS_IRQ_STATUS, 8'h00, "irq cleared");
		`CHK("irq dropped", 1'b0, irq)
		bus(1'b1, OFS_COMMAND, 8'h0C);
		chk_reg(OFS_FLAGS, 8'h1F, "sleep flags");
		bus(1'b1, OFS_FLAGS, 8'h00);
		chk_reg(OFS_FLAGS, 8'h10, "sleep protected");
		bus(1'b1, OFS_COMMAND, 8'h0D);
		chk_reg(OFS_FLAGS, 8'h00, "watchdog clear");
		dummy_count = 0;
		bus(1'b1, OFS_PC_LOW, 8'hAB);
		`CHK("dummy cycles", 1, dummy_count)
		bus(1'b1, OFS_IRQ_MASK, 8'h00);
		chk_reg(OFS_PC_LOW, 8'hAB, "pc low");
		`CHK("pc jump", 12'h0AB, program_counter)
		bus(1'b1, OFS_TABLE_PTR, 8'h34);
		bus(1'b1, OFS_COMMAND, 8'h0B);
		`CHK("table address", 12'h034, seen_tab)
		chk_reg(OFS_TABLE_HIGH, 8'hBE, "table high");
		chk_reg(OFS_WORKING, 8'hEF, "table low");
		bus(1'b1, OFS_TABLE_HIGH, 8'h55);
		chk_reg(OFS_TABLE_HIGH, 8'hBE, "table high ro");
		chk_reg(OFS_IRQ_STATUS, 8'h06, "jump table events");
		`CHK("irq masked", 1'b0, irq)
		chk_reg(OFS_PC_FULL, 8'hAC, "pc full");
		chk_reg(8'h30, 8'h00, "unmapped");
		// or, increment, decrement, load and store, and the operand destination
		cmd(8'h0F, 8'hF0, 8'h03);
		chk_reg(OFS_WORKING, 8'hFF, "or result");
		chk_reg(OFS_FLAGS, 8'h00, "or flags");
		cmd(8'h00, 8'hFF, 8'h17);
		chk_reg(OFS_OPERAND, 8'h00, "inc to operand");
		chk_reg(OFS_FLAGS, 8'h04, "inc flags");
		cmd(8'h00, 8'h00, 8'h08);
		chk_reg(OFS_WORKING, 8'hFF, "dec result");
		chk_reg(OFS_FLAGS, 8'h00, "dec flags");
		cmd(8'h12, 8'h34, 8'h09);
		chk_reg(OFS_WORKING, 8'h34, "load");
		cmd(8'h56, 8'h34, 8'h0A);
		chk_reg(OFS_OPERAND, 8'h56, "store");
		// write without lane 0 is ignored
		bus_sel = 4'hE;
		bus(1'b1, OFS_WORKING, 8'h99);
		bus_sel = 4'hF;
		chk_reg(OFS_WORKING, 8'h56, "lane ignored");
		// table read into the operand
		bus(1'b1, OFS_COMMAND, 8'h1B);
		chk_reg(OFS_OPERAND, 8'hEF, "table to operand");
		chk_reg(OFS_WORKING, 8'h56, "table keeps working");
		// frozen clock enable ignores a timeout
		@(posedge ref_clk);
		clk_en <= 1'b0;
		watchdog_timeout <= 1'b1;
		repeat (3) @(posedge ref_clk);
		watchdog_timeout <= 1'b0;
		clk_en <= 1'b1;
		chk_reg(OFS_FLAGS, 8'h00, "frozen flags");
		// second reset in mid-run
		@(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		chk_reg(OFS_FLAGS, 8'h00, "flags re-reset");
		chk_reg(OFS_WORKING, 8'h00, "working re-reset");
		end_sim();
	end
endmodule : cpu_flags_and_core_registers_bench
`undef CHK
`default_nettype wire
